// [rtl/tlb_pkg.sv]
// Package of constants and types for the tape controller local-bus glue.
package tlb_pkg;

   // Processor address windows.
   localparam logic [19:0] RAM_BASE        = 20'h0_0000;
   localparam logic [19:0] RAM_LAST        = 20'h0_3FFF;
   localparam logic [15:0] MISC_LATCH_BASE = 16'hFA80;
   localparam logic [15:0] MISC_LATCH_LAST = 16'hFAFF;

   // Control latch bit positions.
   localparam int LB_ERASE      = 0;
   localparam int LB_WRGATE     = 1;
   localparam int LB_GAPEN      = 2;
   localparam int LB_CLRWRINIT  = 3;
   localparam int LB_CLRPOLL    = 4;
   localparam int LB_DIAG       = 5;
   localparam int LB_LED1RST    = 6;
   localparam int LB_LED2RST    = 7;

   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [3:0] GAP_COUNT   = 4'h8;

   typedef enum logic [1:0]
   {
      TLB_LANE_WORD,
      TLB_LANE_HIGH,
      TLB_LANE_LOW,
      TLB_LANE_NONE
   } tlb_lane_t;

   // Byte lane decode from upper byte enable and address bit zero.
   function automatic tlb_lane_t tlb_lane(input logic upperN, input logic a0);
      unique case ({upperN, a0})
         2'b00:   tlb_lane = TLB_LANE_WORD;
         2'b01:   tlb_lane = TLB_LANE_HIGH;
         2'b10:   tlb_lane = TLB_LANE_LOW;
         default: tlb_lane = TLB_LANE_NONE;
      endcase
   endfunction : tlb_lane

endpackage : tlb_pkg

// [rtl/tlb_if.sv]
// Interface joining the processor end and the board glue end.
`timescale 1ns/100ps
interface tlb_if;
   import tlb_pkg::*;
   logic        xcvrDirection;
   logic        xcvrEnableN;
   logic        hostStatusRegSelectN;
   logic        hostbusMemSelectN;
   logic        ramSelectN;
   logic        romSelectN;
   logic        writeStrobeN;
   logic        upperByteEnableN;
   logic [19:0] addr;
   logic [15:0] wrData;
   logic [15:0] rdData;
   logic        miscRegSelect;

   modport glue (input xcvrDirection, xcvrEnableN, hostStatusRegSelectN, hostbusMemSelectN,
                 ramSelectN, romSelectN, writeStrobeN, upperByteEnableN, addr, wrData,
                 miscRegSelect, output rdData);
   modport cpu  (output xcvrDirection, xcvrEnableN, hostStatusRegSelectN, hostbusMemSelectN,
                 ramSelectN, romSelectN, writeStrobeN, upperByteEnableN, addr, wrData,
                 miscRegSelect, input rdData);
endinterface : tlb_if

// [rtl/tlb_cpu_end.sv]
// Processor end: runs one local-bus cycle per APB control register write with go bit 7 set.
`timescale 1ns/100ps
module tlb_cpu_end
   import tlb_pkg::*;
(
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Local bus.
   tlb_if.cpu               bus
);
   import tlb_pkg::*;

   localparam logic [11:0] REG_ADDR = 12'h000;
   localparam logic [11:0] REG_DATA = 12'h004;
   localparam logic [11:0] REG_CTRL = 12'h008;
   localparam logic [11:0] REG_STAT = 12'h00C;

   typedef enum logic [1:0] {CPU_IDLE, CPU_SETUP, CPU_STROBE, CPU_DONE} tlb_cpu_t;

   tlb_cpu_t    state_r;
   logic [19:0] addr_r;
   logic [15:0] data_r;
   logic [15:0] rd_r;
   logic [7:0]  ctrl_r;
   logic        acc;

   ////////////////////////////////////////////////////////////////////////////////
   // Register access; control fields: 0 write, 1 ram, 2 misc, 3 hostmem,
   // 4 hoststatus, 5 upper byte enable n, 7 go.
   assign acc     = psel && penable;
   assign pready  = 1'b1;
   assign pslverr = acc && (paddr[11:4] != 8'h00 || paddr[1:0] != 2'b00);

   always_comb
   begin
      unique case (paddr)
         REG_ADDR: prdata = {12'h000, addr_r};
         REG_DATA: prdata = {16'h0000, data_r};
         REG_CTRL: prdata = {24'h00_0000, ctrl_r};
         REG_STAT: prdata = {15'h0000, state_r != CPU_IDLE, rd_r};
         default:  prdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         addr_r <= 20'h0_0000;
         data_r <= 16'h0000;
         ctrl_r <= 8'h00;
      end
      else if (acc && pwrite && state_r == CPU_IDLE)
      begin
         if (paddr == REG_ADDR) addr_r <= pwdata[19:0];
         if (paddr == REG_DATA) data_r <= pwdata[15:0];
         if (paddr == REG_CTRL) ctrl_r <= pwdata[7:0];
      end
      else if (state_r == CPU_DONE)
      begin
         ctrl_r[7] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bus cycle sequencer.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         state_r <= CPU_IDLE;
         rd_r    <= 16'h0000;
      end
      else
      begin
         unique case (state_r)
            CPU_IDLE:   if (ctrl_r[7]) state_r <= CPU_SETUP;
            CPU_SETUP:  state_r <= CPU_STROBE;
            CPU_STROBE:
            begin
               if (!ctrl_r[0]) rd_r <= bus.rdData;
               state_r <= CPU_DONE;
            end
            CPU_DONE:   state_r <= CPU_IDLE;
         endcase
      end
   end

   logic active;
   assign active = state_r == CPU_SETUP || state_r == CPU_STROBE;

   assign bus.addr                 = addr_r;
   assign bus.wrData               = data_r;
   assign bus.xcvrDirection        = ctrl_r[0];
   assign bus.xcvrEnableN          = !active;
   assign bus.ramSelectN           = !(active && ctrl_r[1]);
   assign bus.romSelectN           = 1'b1;
   assign bus.miscRegSelect        = active && ctrl_r[2];
   assign bus.hostbusMemSelectN    = !(active && ctrl_r[3]);
   assign bus.hostStatusRegSelectN = !(active && ctrl_r[4]);
   assign bus.upperByteEnableN     = ctrl_r[5];
   assign bus.writeStrobeN         = !(state_r == CPU_STROBE && ctrl_r[0]);

endmodule : tlb_cpu_end

// [rtl/tlb_glue_end.sv]
// Board glue end: transceiver gating, RAM, control latch, gap detect, host flags.
//
// Operation
// - Direction low passes data toward processor.
// - Direction high drives processor outputs outward.
// - Enable only when no host access active.
// - RAM answers addresses 00000 through 03FFF.
// - RAM writes use write strobe, lane selected.
// - Upper enable and bit zero pick lanes.
// - Latch write sets/clears bit by address.
// - Latch bit order erase through LED two.
// - Drive erases only with gate, unprotected; here erase needs only its latch bit, outside diagnostic mode.
// - Write gate and erase drive transmitter.
// - Gap register shifts on write clock.
// - Count eight toggles gap flip-flop, interrupt.
// - Host status write sets write-init flag.
// - Processor polls and clears write-init flag.
// - Clear-poll bit clears poll-init flag.
// - Diagnostic mode loops clock, disables transmitter.
// - Reset clears latch, LED one lit.
// - LED two lit until its reset bit.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
module tlb_glue_end
   import tlb_pkg::*;
(
   // Clock and reset.
   input  wire logic sys_clk,
   input  wire logic rst,
   // Processor side.
   tlb_if.glue       bus,
   // Drive side pins.
   input  wire logic driveWrClk,
   input  wire logic driveRdClk,
   input  wire logic diagClk,
   output logic      driveEraseOut,
   output logic      driveWriteGateOut,
   output logic      driveTxEnable,
   // Host bus receivers.
   input  wire logic hostAddrMatch,
   input  wire logic xcvrDataLine1,
   input  wire logic busSyncRx,
   input  wire logic busDataOutRx,
   input  wire logic busDataInRx,
   // Status to processor and board.
   output logic      writeInitFlag,
   output logic      pollInitFlag,
   output logic      gapToggle,
   output logic      xcvrOutEnable,
   output logic      xcvrTowardCpu,
   output logic      led1On,
   output logic      led2On
);
   import tlb_pkg::*;

   logic [7:0]  latch_r;
   logic [15:0] ram [0:8191];
   logic [15:0] rdData_r;
   logic [2:0]  wrS_r, rdS_r, dgS_r;
   logic [4:0]  hostS1_r, hostS2_r;
   logic [3:0]  gapCnt_r;
   logic        wrEdge, rdEdge, dgEdge, shiftEv;
   logic        xcvrOn;
   logic        ramHit;
   tlb_lane_t   lane;

   ////////////////////////////////////////////////////////////////////////////////
   // Transceiver gating.
   assign xcvrOn = !bus.xcvrEnableN && bus.hostbusMemSelectN
                   && bus.hostStatusRegSelectN;
   assign xcvrOutEnable = xcvrOn;
   assign xcvrTowardCpu = !bus.xcvrDirection;

   ////////////////////////////////////////////////////////////////////////////////
   // RAM with byte lanes.
   assign ramHit = !bus.ramSelectN && bus.romSelectN && xcvrOn
                   && bus.addr <= RAM_LAST;
   assign lane   = tlb_lane(bus.upperByteEnableN, bus.addr[0]);

   always_ff @(posedge sys_clk)
   begin
      if (ramHit && bus.xcvrDirection && !bus.writeStrobeN)
      begin
         if (lane == TLB_LANE_WORD || lane == TLB_LANE_LOW)
            ram[bus.addr[13:1]][7:0] <= bus.wrData[7:0];
         if (lane == TLB_LANE_WORD || lane == TLB_LANE_HIGH)
            ram[bus.addr[13:1]][15:8] <= bus.wrData[15:8];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         rdData_r <= 16'h0000;
      else if (ramHit && !bus.xcvrDirection)
      begin
         unique case (lane)
            TLB_LANE_WORD: rdData_r <= ram[bus.addr[13:1]];
            TLB_LANE_HIGH: rdData_r <= {ram[bus.addr[13:1]][15:8], 8'h00};
            TLB_LANE_LOW:  rdData_r <= {8'h00, ram[bus.addr[13:1]][7:0]};
            TLB_LANE_NONE: rdData_r <= 16'h0000;
         endcase
      end
   end
   assign bus.rdData = rdData_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Addressable control latch.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         latch_r <= LATCH_RESET;
      else if (bus.miscRegSelect && !bus.writeStrobeN
               && bus.addr[15:0] >= MISC_LATCH_BASE && bus.addr[15:0] <= MISC_LATCH_LAST)
         latch_r[bus.addr[3:1]] <= bus.wrData[0];
   end

   assign driveTxEnable     = !latch_r[LB_DIAG];
   assign driveEraseOut     = latch_r[LB_ERASE] && driveTxEnable;
   assign driveWriteGateOut = latch_r[LB_WRGATE] && driveTxEnable;
   assign led1On            = !latch_r[LB_LED1RST];
   assign led2On            = !latch_r[LB_LED2RST];

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detect on third stage.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         wrS_r    <= 3'b000;
         rdS_r    <= 3'b000;
         dgS_r    <= 3'b000;
         hostS1_r <= 5'b00000;
         hostS2_r <= 5'b00000;
      end
      else
      begin
         wrS_r    <= {wrS_r[1:0], driveWrClk};
         rdS_r    <= {rdS_r[1:0], driveRdClk};
         dgS_r    <= {dgS_r[1:0], diagClk};
         hostS1_r <= {hostAddrMatch, xcvrDataLine1, busSyncRx, busDataOutRx, busDataInRx};
         hostS2_r <= hostS1_r;
      end
   end
   assign wrEdge  = wrS_r[1] && !wrS_r[2];
   assign rdEdge  = rdS_r[1] && !rdS_r[2];
   assign dgEdge  = dgS_r[1] && !dgS_r[2];
   assign shiftEv = latch_r[LB_DIAG] ? dgEdge : wrEdge;

   ////////////////////////////////////////////////////////////////////////////////
   // Gap detect shift counter and toggle.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         gapCnt_r  <= 4'h0;
         gapToggle <= 1'b0;
      end
      else if (rdEdge && !latch_r[LB_DIAG])
         gapCnt_r <= 4'h0;
      else if (shiftEv && latch_r[LB_GAPEN])
      begin
         if (gapCnt_r == GAP_COUNT - 4'h1)
         begin
            gapCnt_r  <= 4'h0;
            gapToggle <= !gapToggle;
         end
         else
            gapCnt_r <= gapCnt_r + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Host flags; a set wins over a clear in the same cycle.
   logic setWr, setPoll;
   assign setWr   = hostS2_r[4] && hostS2_r[3] && hostS2_r[2] && hostS2_r[1];
   assign setPoll = hostS2_r[4] && !hostS2_r[3] && hostS2_r[2] && hostS2_r[0];

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         writeInitFlag <= 1'b0;
         pollInitFlag  <= 1'b0;
      end
      else
      begin
         if (setWr)
            writeInitFlag <= 1'b1;
         else if (latch_r[LB_CLRWRINIT])
            writeInitFlag <= 1'b0;
         if (setPoll)
            pollInitFlag <= 1'b1;
         else if (latch_r[LB_CLRPOLL])
            pollInitFlag <= 1'b0;
      end
   end

endmodule : tlb_glue_end

// [test/tlb_assertions.sv]
// Checker for the local-bus glue, watching the joining interface and glue pins.
`timescale 1ns/100ps
module tlb_assertions
(
   // Clock and reset.
   input wire logic        sys_clk,
   input wire logic        rst,
   // Interface signals.
   input wire logic        xcvrDirection,
   input wire logic        xcvrEnableN,
   input wire logic        hostStatusRegSelectN,
   input wire logic        hostbusMemSelectN,
   input wire logic        writeStrobeN,
   input wire logic        miscRegSelect,
   input wire logic [19:0] addr,
   input wire logic [15:0] wrData,
   // Glue outputs.
   input wire logic        driveEraseOut,
   input wire logic        driveWriteGateOut,
   input wire logic        driveTxEnable,
   input wire logic        xcvrOutEnable,
   input wire logic        xcvrTowardCpu,
   input wire logic        led1On,
   input wire logic        led2On,
   input wire logic        writeInitFlag,
   input wire logic        gapToggle
);
   logic       lw;
   logic [2:0] ix;
   assign lw = miscRegSelect && !writeStrobeN;
   assign ix = addr[3:1];
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////
   a_dir_toward: assert property (xcvrTowardCpu == !xcvrDirection)
      else $error("transceiver direction wrong");
   a_xcvr_gate: assert property (xcvrOutEnable ==
      (!xcvrEnableN && hostbusMemSelectN && hostStatusRegSelectN)) else $error("enable wrong");
   a_erase_set: assert property (lw && ix == 3'h0 && wrData[0] && driveTxEnable
      |=> driveEraseOut) else $error("erase not set");
   a_gate_clear: assert property (lw && ix == 3'h1 && !wrData[0]
      |=> !driveWriteGateOut) else $error("write gate not cleared");
   a_diag_tx: assert property (lw && ix == 3'h5
      |=> driveTxEnable != $past(wrData[0])) else $error("transmitter wrong");
   a_led_one: assert property (lw && ix == 3'h6
      |=> led1On == !$past(wrData[0])) else $error("led one wrong");
   a_led_two_hold: assert property (lw && ix != 3'h7 |=> $stable(led2On))
      else $error("led two disturbed");
   a_diag_mask: assert property (!driveTxEnable |->
      !driveEraseOut && !driveWriteGateOut) else $error("drive not masked");
   a_reset_state: assert property ($fell(rst) |-> led1On && led2On &&
      driveTxEnable && !writeInitFlag && !gapToggle) else $error("reset state wrong");
   a_strobe_pulse: assert property ($fell(writeStrobeN) |=> writeStrobeN)
      else $error("strobe too long");
   ////////////////////////////////////////////////////////////////////////////
   c_latch_set: cover property (lw && wrData[0]);
   c_flag_set: cover property ($rose(writeInitFlag));
   c_gap: cover property ($changed(gapToggle));
endmodule : tlb_assertions

// [test/tape_ctrl_local_bus_control_test.sv]
// Testbench joining processor end and glue end, driven over APB.
`timescale 1ns/100ps
module tape_ctrl_local_bus_control_test;
   import tlb_pkg::*;
   logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, perr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [2:0]  pc;
   logic        hostAddrMatch, xcvrDataLine1, busSyncRx, busDataOutRx, busDataInRx;
   logic        driveEraseOut, driveWriteGateOut, driveTxEnable, writeInitFlag;
   logic        pollInitFlag, gapToggle, xcvrOutEnable, xcvrTowardCpu, led1On, led2On;
   logic [7:0]  lat;
   int          failCount, nTests;
   tlb_if u_tlb_if();
   tlb_cpu_end u_tlb_cpu_end(.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bus(u_tlb_if.cpu));
   tlb_glue_end u_tlb_glue_end(.sys_clk(sys_clk), .rst(rst), .bus(u_tlb_if.glue),
      .driveWrClk(pc[0]), .driveRdClk(pc[1]), .diagClk(pc[2]), .driveEraseOut(driveEraseOut),
      .driveWriteGateOut(driveWriteGateOut), .driveTxEnable(driveTxEnable),
      .hostAddrMatch(hostAddrMatch), .xcvrDataLine1(xcvrDataLine1), .busSyncRx(busSyncRx),
      .busDataOutRx(busDataOutRx), .busDataInRx(busDataInRx), .writeInitFlag(writeInitFlag),
      .pollInitFlag(pollInitFlag), .gapToggle(gapToggle), .xcvrOutEnable(xcvrOutEnable),
      .xcvrTowardCpu(xcvrTowardCpu), .led1On(led1On), .led2On(led2On));
   tlb_assertions u_tlb_assertions(.sys_clk(sys_clk), .rst(rst),
      .xcvrDirection(u_tlb_if.xcvrDirection), .xcvrEnableN(u_tlb_if.xcvrEnableN),
      .hostStatusRegSelectN(u_tlb_if.hostStatusRegSelectN),
      .hostbusMemSelectN(u_tlb_if.hostbusMemSelectN), .writeStrobeN(u_tlb_if.writeStrobeN),
      .miscRegSelect(u_tlb_if.miscRegSelect), .addr(u_tlb_if.addr), .wrData(u_tlb_if.wrData),
      .driveEraseOut(driveEraseOut), .driveWriteGateOut(driveWriteGateOut),
      .driveTxEnable(driveTxEnable), .xcvrOutEnable(xcvrOutEnable),
      .xcvrTowardCpu(xcvrTowardCpu), .led1On(led1On), .led2On(led2On),
      .writeInitFlag(writeInitFlag), .gapToggle(gapToggle));
   initial
   begin
      sys_clk = 0;
      forever #10 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task summarize;
      $display("comparisons %0d mismatches %0d", nTests, failCount);
      if (failCount == 0 && nTests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize
   task cmp_bit(input logic g, input logic e);
      nTests++;
      if (g !== e)
      begin
         failCount++;
         $display("[ERR] %0t bit got %b expected %b", $time, g, e);
      end
   endtask : cmp_bit
   task cmp_word(input logic [15:0] g, input logic [15:0] e);
      nTests++;
      if (g !== e)
      begin
         failCount++;
         $display("[ERR] %0t word got %h expected %h", $time, g, e);
      end
   endtask : cmp_word
   // One APB transfer; read data and error are taken at the answering edge.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rdv = prdata;
      perr = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   // One local-bus cycle, then wait until the processor end is idle.
   task op(input logic [7:0] c, input logic [19:0] a, input logic [15:0] d);
      apb(1, 12'h000, {12'h000, a});
      apb(1, 12'h004, {16'h0000, d});
      apb(1, 12'h008, {24'h00_0000, c});
      do apb(0, 12'h00C, 32'h0000_0000); while (rdv[16] !== 1'b0);
      repeat (2) @(posedge sys_clk);
   endtask : op
   // Latch write; only data bit zero is meant to count.
   task wl(input int i, input logic v);
      op(8'h85, 20'({4'h0, MISC_LATCH_BASE} + 2 * i), v ? 16'h0001 : 16'hFFFE);
      lat[i] = v;
   endtask : wl
   task chk;
      cmp_bit(driveEraseOut, lat[LB_ERASE] & ~lat[LB_DIAG]);
      cmp_bit(driveWriteGateOut, lat[LB_WRGATE] & ~lat[LB_DIAG]);
      cmp_bit(driveTxEnable, ~lat[LB_DIAG]);
      cmp_bit(led1On, ~lat[LB_LED1RST]);
      cmp_bit(led2On, ~lat[LB_LED2RST]);
   endtask : chk
   task host(input logic dl1, input logic rd);
      @(posedge sys_clk);
      {hostAddrMatch, xcvrDataLine1, busSyncRx, busDataOutRx, busDataInRx}
         <= {1'b1, dl1, 1'b1, !rd, rd};
      repeat (4) @(posedge sys_clk);
      {hostAddrMatch, busSyncRx, busDataOutRx, busDataInRx} <= 4'h0;
      repeat (5) @(posedge sys_clk);
   endtask : host
   task pulse(input int k, input int n);
      repeat (n)
      begin
         @(posedge sys_clk);
         pc[k] <= 1;
         repeat (4) @(posedge sys_clk);
         pc[k] <= 0;
         repeat (3) @(posedge sys_clk);
      end
   endtask : pulse
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (30000) @(posedge sys_clk);
      failCount++;
      $display("[ERR] %0t run did not finish", $time);
      summarize;
   end
   initial
   begin
      {rst, psel, penable, pwrite, paddr, pwdata, pc} = {1'b1, 50'h0};
      {hostAddrMatch, xcvrDataLine1, busSyncRx, busDataOutRx, busDataInRx} = 5'h0;
      {lat, failCount, nTests} = 0;
      repeat (8) @(posedge sys_clk);
      rst <= 0;
      @(posedge sys_clk);
      chk;
      for (int i = 0; i < 8; i++)
      begin
         wl(i, 1);
         chk;
      end
      for (int i = 7; i >= 0; i--)
      begin
         wl(i, 0);
         chk;
      end
      op(8'h83, 20'h0_0010, 16'hA5C3);
      op(8'h83, RAM_LAST - 1, 16'h1234);
      op(8'hA3, 20'h0_0010, 16'h00FF);
      op(8'h83, 20'h0_0011, 16'h7700);
      op(8'h82, 20'h0_0010, 16'h0000);
      cmp_word(rdv[15:0], 16'h77FF);
      op(8'h82, RAM_LAST - 1, 16'h0000);
      cmp_word(rdv[15:0], 16'h1234);
      op(8'h8B, 20'h0_0010, 16'hDEAD);
      op(8'h93, 20'h0_0010, 16'hBEEF);
      op(8'h82, 20'h0_0010, 16'h0000);
      cmp_word(rdv[15:0], 16'h77FF);
      host(1, 0);
      cmp_bit(writeInitFlag, 1);
      wl(LB_CLRWRINIT, 1);
      cmp_bit(writeInitFlag, 0);
      wl(LB_CLRWRINIT, 0);
      host(0, 1);
      cmp_bit(pollInitFlag, 1);
      wl(LB_CLRPOLL, 1);
      cmp_bit(pollInitFlag, 0);
      wl(LB_CLRPOLL, 0);
      wl(LB_GAPEN, 1);
      pulse(0, 7);
      pulse(1, 1);
      pulse(0, 7);
      cmp_bit(gapToggle, 0);
      pulse(0, 1);
      cmp_bit(gapToggle, 1);
      pulse(1, 1);
      wl(LB_DIAG, 1);
      pulse(2, 8);
      cmp_bit(gapToggle, 0);
      apb(0, 12'h010, 32'h0000_0000);
      cmp_bit(perr, 1);
      summarize;
   end
endmodule : tape_ctrl_local_bus_control_test
